// ==== rtl/csq_pkg.sv ====
// Package with constants and carrier types of the slot qualifier and power control block.
// Overview of operation
// - Upper address latch transparent while BALE high.
// - AEN high marks a DMA cycle.
// - Memory access starts only with REFRESH# high.
// - Wait-state timing counts SYSCLK edges.
// - Interrupt pulse width counted in SYSCLK cycles.
// - Explicit clear pulse timed by SYSCLK.
// - Control bit 0 function timed by SYSCLK.
// - Ready-line high drive timed by SYSCLK.
// - Drive released line high one SYSCLK, then float.
// - ATA mode puts activity on IRQ12.
// - Voltage sense change raises enabled interrupt.
// - Interface status bit 7 shows inverted sense.
// - Low-volt supply enable low when selected.
// - High-volt supply enable low when selected.
// - Never both supply enables low together.
// - Select A gives 5V, B gives 12V.
// - Both programming selects high is reproduced.
// - Each select drives its own programming pin.
// - Power outputs come from two control registers.
package csq_pkg;

  // Clock and SYSCLK rates; SYSCLK is sampled by pclk.
  localparam int PCLK_KHZ = 250000;
  localparam int SYSCLK_NOM_KHZ = 8330;
  localparam int SYSCLK_MAX_KHZ = 11000;
  localparam int SYSCLK_MIN_PCLKS = PCLK_KHZ / SYSCLK_MAX_KHZ;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] PWR_IDX = 8'h02;
  localparam logic [7:0] MIX_IDX = 8'h2f;
  localparam logic [7:0] CDC_IDX = 8'h30;
  localparam logic [7:0] SC_IDX = 8'h31;
  localparam logic [7:0] IFS_IDX = 8'h32;

  // Field positions.
  localparam int PWR_VCC_ON = 4;
  localparam int MIX_LOW_VOLT = 1;
  localparam int CDC_SW_EVENT = 0;
  localparam int CDC_GPI_EN = 2;
  localparam int CDC_EXPLICIT = 3;
  localparam int CDC_ATA = 4;
  localparam int CDC_ZWS = 5;
  localparam int SC_GPI = 0;
  localparam int SC_SW = 1;
  localparam int IFS_RDY = 0;
  localparam int IFS_ZWS = 1;
  localparam int IFS_IRQ = 2;
  localparam int IFS_SENSE = 7;

  // Reset values.
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] MIX_RST = 8'h00;
  localparam logic [7:0] CDC_RST = 8'h00;
  localparam logic [1:0] SC_RST = 2'h0;

  // Default SYSCLK counts.
  localparam int WAIT_SYSCLKS = 2;
  localparam int HOST_INTERRUPT_OUT_N_SYSCLKS = 4;

  // Host bus qualifiers.
  typedef struct packed {
    logic bale;
    logic aen;
    logic refresh_n;
    logic mem_req;
    logic [6:0] la;
  } csq_host_type;

  // Slot power switch drives.
  typedef struct packed {
    logic low_volt_en_n;
    logic high_volt_en_n;
    logic prog_sel_a;
    logic prog_sel_b;
  } csq_power_type;

  // Ready-line sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_RDY_KICK = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_ZLOW = 3'b100,
    ST_Z_KICK = 3'b101
  } csq_state_type;

endpackage

// ==== rtl/csq_slot_ctrl.sv ====
// Host qualifier, ready-line timing, status change and slot power control with an APB slave.
//
// Local design decisions: the address map and register access over APB.
module csq_slot_ctrl #(
  parameter int WAIT_CNT = csq_pkg::WAIT_SYSCLKS,
  parameter int HOST_INTERRUPT_OUT_N_CNT = csq_pkg::HOST_INTERRUPT_OUT_N_SYSCLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire csq_pkg::csq_host_type host,
  input wire logic sysclk,
  input wire logic voltage_sense_input,
  output logic [6:0] la_latched,
  output logic dma_cycle,
  output logic mem_cycle,
  input wire logic iochrdy_i,
  output logic iochrdy_o,
  output logic iochrdy_oe,
  input wire logic zerows_n_i,
  output logic zerows_n_o,
  output logic zerows_n_oe,
  output logic host_interrupt_out_n,
  output logic irq12_o,
  output csq_pkg::csq_power_type power
);

  logic [7:0] pwr_q;
  logic [7:0] mix_q;
  logic [7:0] cdc_q;
  logic [1:0] sc_q;
  logic [1:0] clr_pend_q;
  logic sysclk_q;
  logic sense_q;
  logic mem_req_q;
  logic [6:0] la_q;
  logic [3:0] wait_q;
  logic [3:0] host_interrupt_out_n_q;
  logic [31:0] rdata_q;
  logic err_q;
  csq_pkg::csq_state_type st_q;
  logic sys_rise;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] idx;
  logic sense_chg;
  logic [1:0] sc_set;
  logic mem_start;
  logic [7:0] ifs;

  // Bus decode; the slave answers without wait states.
  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = err_q;

  // SYSCLK is synchronous to pclk, so one delayed copy gives its edge.
  assign sys_rise = sysclk && !sysclk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_q <= 1'b0;
      sense_q <= 1'b1;
      mem_req_q <= 1'b0;
    end else begin
      sysclk_q <= sysclk;
      sense_q <= voltage_sense_input;
      mem_req_q <= host.mem_req;
    end
  end

  // Upper address half-latch: follows the lines while BALE is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      la_q <= 7'h00;
    end else if (host.bale) begin
      la_q <= host.la;
    end
  end
  assign la_latched = host.bale ? host.la : la_q;

  // A memory cycle may begin only outside refresh and outside DMA.
  assign dma_cycle = host.aen;
  assign mem_start = host.mem_req && !mem_req_q && host.refresh_n && !host.aen;

  // Power and mixed voltage registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= csq_pkg::PWR_RST;
      mix_q <= csq_pkg::MIX_RST;
    end else if (wr_acc && idx == csq_pkg::PWR_IDX) begin
      pwr_q <= pwdata[7:0];
    end else if (wr_acc && idx == csq_pkg::MIX_IDX) begin
      mix_q <= pwdata[7:0];
    end
  end

  // Bit 0 is a software event request that lives until the next SYSCLK edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdc_q <= csq_pkg::CDC_RST;
    end else if (wr_acc && idx == csq_pkg::CDC_IDX) begin
      cdc_q <= pwdata[7:0];
    end else if (sys_rise) begin
      cdc_q[csq_pkg::CDC_SW_EVENT] <= 1'b0;
    end
  end

  // Status change sources; the sense input only counts when enabled.
  assign sense_chg = (sense_q != voltage_sense_input) && cdc_q[csq_pkg::CDC_GPI_EN];
  assign sc_set[csq_pkg::SC_GPI] = sense_chg;
  assign sc_set[csq_pkg::SC_SW] = cdc_q[csq_pkg::CDC_SW_EVENT] && sys_rise;

  // Explicit mode queues a write-one clear that is applied at the next SYSCLK edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pend_q <= 2'h0;
    end else if (wr_acc && idx == csq_pkg::SC_IDX && cdc_q[csq_pkg::CDC_EXPLICIT]) begin
      clr_pend_q <= clr_pend_q | pwdata[1:0];
    end else if (sys_rise) begin
      clr_pend_q <= 2'h0;
    end
  end

  // Sticky flags; a set in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q <= csq_pkg::SC_RST;
    end else if (cdc_q[csq_pkg::CDC_EXPLICIT]) begin
      sc_q <= (sys_rise ? (sc_q & ~clr_pend_q) : sc_q) | sc_set;
    end else if (rd_acc && idx == csq_pkg::SC_IDX) begin
      sc_q <= sc_set;
    end else begin
      sc_q <= sc_q | sc_set;
    end
  end

  // Each new event restarts a low pulse of a fixed SYSCLK count on the interrupt pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_interrupt_out_n_q <= 4'h0;
    end else if (|sc_set) begin
      host_interrupt_out_n_q <= 4'(HOST_INTERRUPT_OUT_N_CNT);
    end else if (sys_rise && host_interrupt_out_n_q != 4'h0) begin
      host_interrupt_out_n_q <= host_interrupt_out_n_q - 4'h1;
    end
  end
  assign host_interrupt_out_n = (host_interrupt_out_n_q == 4'h0);

  // In ATA mode IRQ12 sinks LED current during card access; otherwise it shows pending flags.
  assign irq12_o = cdc_q[csq_pkg::CDC_ATA] ? !mem_cycle : (|sc_q);

  // Ready-line sequencer: stretch with IOCHRDY or shorten with ZEROWS#, then kick high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= csq_pkg::ST_IDLE;
      wait_q <= 4'h0;
    end else begin
      unique case (st_q)
        csq_pkg::ST_IDLE: begin
          if (mem_start && cdc_q[csq_pkg::CDC_ZWS]) begin
            st_q <= csq_pkg::ST_ZLOW;
          end else if (mem_start) begin
            st_q <= csq_pkg::ST_HOLD;
            wait_q <= 4'(WAIT_CNT);
          end
        end
        csq_pkg::ST_HOLD: begin
          if (sys_rise && wait_q <= 4'h1) begin
            st_q <= csq_pkg::ST_RDY_KICK;
          end else if (sys_rise) begin
            wait_q <= wait_q - 4'h1;
          end
        end
        csq_pkg::ST_RDY_KICK: begin
          if (sys_rise) begin
            st_q <= csq_pkg::ST_ACTIVE;
          end
        end
        csq_pkg::ST_ACTIVE: begin
          if (!host.mem_req) begin
            st_q <= csq_pkg::ST_IDLE;
          end
        end
        csq_pkg::ST_ZLOW: begin
          if (!host.mem_req) begin
            st_q <= csq_pkg::ST_Z_KICK;
          end
        end
        csq_pkg::ST_Z_KICK: begin
          if (sys_rise) begin
            st_q <= csq_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= csq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Open-drain lines; the short high drive saves a strong pull-up.
  assign iochrdy_o = (st_q == csq_pkg::ST_RDY_KICK);
  assign iochrdy_oe = (st_q == csq_pkg::ST_HOLD) || (st_q == csq_pkg::ST_RDY_KICK);
  assign zerows_n_o = (st_q == csq_pkg::ST_Z_KICK);
  assign zerows_n_oe = (st_q == csq_pkg::ST_ZLOW) || (st_q == csq_pkg::ST_Z_KICK);
  assign mem_cycle = (st_q != csq_pkg::ST_IDLE) && (st_q != csq_pkg::ST_Z_KICK);

  // Slot power: the supply select is one bit, so the two enables exclude each other.
  assign power.low_volt_en_n = !(pwr_q[csq_pkg::PWR_VCC_ON] && mix_q[csq_pkg::MIX_LOW_VOLT]);
  assign power.high_volt_en_n = !(pwr_q[csq_pkg::PWR_VCC_ON] && !mix_q[csq_pkg::MIX_LOW_VOLT]);
  // Code 11 drives both programming selects, as the board must tolerate.
  assign power.prog_sel_a = pwr_q[0];
  assign power.prog_sel_b = pwr_q[1];

  // Interface status shows live pin levels and the inverted sense input.
  always_comb begin
    ifs = 8'h00;
    ifs[csq_pkg::IFS_RDY] = iochrdy_i;
    ifs[csq_pkg::IFS_ZWS] = zerows_n_i;
    ifs[csq_pkg::IFS_IRQ] = |sc_q;
    ifs[csq_pkg::IFS_SENSE] = !voltage_sense_input;
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      unique case (idx)
        csq_pkg::PWR_IDX: rdata_q[7:0] <= pwr_q;
        csq_pkg::MIX_IDX: rdata_q[7:0] <= mix_q;
        csq_pkg::CDC_IDX: rdata_q[7:0] <= cdc_q;
        csq_pkg::SC_IDX: rdata_q[1:0] <= sc_q;
        csq_pkg::IFS_IDX: rdata_q[7:0] <= ifs;
        default: err_q <= 1'b1;
      endcase
    end
  end

  // Checks on the block's outputs and internal state.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_la_transparent: assert property (host.bale |-> la_latched == host.la)
    else $error("address latch not transparent");
  a_la_hold: assert property (!host.bale && $past(!host.bale) |-> $stable(la_latched))
    else $error("latched address moved");
  a_dma_no_start: assert property (host.aen |-> !mem_start)
    else $error("memory cycle started in DMA");
  a_refresh_block: assert property (st_q == csq_pkg::ST_IDLE && !host.refresh_n
    |=> st_q == csq_pkg::ST_IDLE)
    else $error("memory cycle started during refresh");
  a_wait_on_edge: assert property (st_q == csq_pkg::ST_HOLD && !sys_rise |=> $stable(wait_q))
    else $error("wait count moved without SYSCLK");
  a_host_interrupt_out_n_width: assert property ($rose(!host_interrupt_out_n) |-> host_interrupt_out_n_q == 4'(HOST_INTERRUPT_OUT_N_CNT))
    else $error("interrupt pulse width wrong");
  a_clear_timing: assert property (cdc_q[csq_pkg::CDC_EXPLICIT] && !sys_rise && ~|sc_set
    |=> $stable(sc_q))
    else $error("status cleared off SYSCLK");
  a_sw_event: assert property (cdc_q[csq_pkg::CDC_SW_EVENT] && sys_rise
    |=> sc_q[csq_pkg::SC_SW] && !host_interrupt_out_n)
    else $error("software event lost");
  a_kick_one_edge: assert property (iochrdy_o && iochrdy_oe && sys_rise |=> !iochrdy_oe)
    else $error("ready line driven high too long");
  a_zws_kick: assert property ($fell(zerows_n_oe) |-> $past(sys_rise))
    else $error("zero-wait line released off SYSCLK");
  a_ata_led: assert property (cdc_q[csq_pkg::CDC_ATA] |-> irq12_o == !mem_cycle)
    else $error("activity output wrong");
  a_sense_irq: assert property (sense_chg |=> sc_q[csq_pkg::SC_GPI] ##1 !host_interrupt_out_n)
    else $error("sense change not flagged");
  a_sense_status: assert property (ifs[csq_pkg::IFS_SENSE] != voltage_sense_input)
    else $error("sense status not inverted");
  a_supply_excl: assert property (power.low_volt_en_n || power.high_volt_en_n)
    else $error("both supply enables asserted");
  a_supply_sel: assert property (pwr_q[csq_pkg::PWR_VCC_ON] |-> (power.low_volt_en_n
    == !mix_q[csq_pkg::MIX_LOW_VOLT]) && !(power.low_volt_en_n && power.high_volt_en_n))
    else $error("supply select wrong");
  a_prog_both: assert property (pwr_q[1:0] == 2'h3 |-> power.prog_sel_a && power.prog_sel_b)
    else $error("programming selects not both high");
  a_reset_off: assert property ($rose(presetn) |-> power == 4'b1100)
    else $error("slot power on after reset");

  c_wait_cycle: cover property (st_q == csq_pkg::ST_HOLD ##[1:200] st_q == csq_pkg::ST_ACTIVE);
  c_zero_wait: cover property (st_q == csq_pkg::ST_ZLOW ##[1:200] st_q == csq_pkg::ST_Z_KICK);
  c_sense_host_interrupt_out_n: cover property (sense_chg ##[1:50] host_interrupt_out_n);
  c_explicit_clr: cover property (cdc_q[csq_pkg::CDC_EXPLICIT] && |clr_pend_q && sys_rise);

endmodule

// ==== dv/csq_slot_partner.sv ====
// Far-side model: host SYSCLK source, pulled-up sense pin and pulled-up ready lines.
module csq_slot_partner #(
  parameter int HALF = 15
) (
  input wire logic pclk,
  input wire logic card_low_volt,
  input wire logic iochrdy_o,
  input wire logic iochrdy_oe,
  input wire logic zerows_n_o,
  input wire logic zerows_n_oe,
  output logic sysclk,
  output logic voltage_sense_input,
  output logic iochrdy_i,
  output logic zerows_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;

  // SYSCLK runs free at about 8.33 MHz, derived from pclk edges.
  initial sysclk = 1'b0;
  always @(posedge pclk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      sysclk <= ~sysclk;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // A low-volt card grounds the sense pin; any other card leaves it to the pull-up.
  assign voltage_sense_input = card_low_volt ? 1'b0 : 1'b1;
  // Released open-drain lines float up to the pull-up level.
  assign iochrdy_i = iochrdy_oe ? iochrdy_o : 1'b1;
  assign zerows_n_i = zerows_n_oe ? zerows_n_o : 1'b1;
endmodule

// ==== dv/test_csq_slot_ctrl.sv ====
// Self-checking bench of the slot qualifier and power control block.
module test_csq_slot_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] mix;
    logic [3:0] pw;
  } csq_row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  csq_pkg::csq_host_type host = '{1'b0, 1'b0, 1'b1, 1'b0, 7'h00};
  logic sysclk, sense, iochrdy_i, iochrdy_o, iochrdy_oe, zerows_n_i, zerows_n_o, zerows_n_oe;
  logic host_interrupt_out_n_n, irq12_o, dma_cycle, mem_cycle, low_volt = 1'b0;
  logic [6:0] la_latched;
  csq_pkg::csq_power_type power;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int checks = 0;
  int k;
  csq_row_type rows [7] = '{'{8'h00, 8'h00, 4'hc}, '{8'h10, 8'h00, 4'h8},
    '{8'h10, 8'h02, 4'h4}, '{8'h11, 8'h02, 4'h6}, '{8'h12, 8'h00, 4'h9},
    '{8'h13, 8'h02, 4'h7}, '{8'h03, 8'h02, 4'hf}};

  // Half period of 2 ns gives the 250 MHz bus clock.
  always #2 pclk = ~pclk;

  csq_slot_ctrl #(.WAIT_CNT(2), .HOST_INTERRUPT_OUT_N_CNT(4)) i_csq_slot_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host(host), .sysclk(sysclk),
    .voltage_sense_input(sense), .la_latched(la_latched), .dma_cycle(dma_cycle),
    .mem_cycle(mem_cycle), .iochrdy_i(iochrdy_i), .iochrdy_o(iochrdy_o),
    .iochrdy_oe(iochrdy_oe), .zerows_n_i(zerows_n_i), .zerows_n_o(zerows_n_o),
    .zerows_n_oe(zerows_n_oe), .host_interrupt_out_n(host_interrupt_out_n_n), .irq12_o(irq12_o),
    .power(power));

  csq_slot_partner #(.HALF(15)) i_csq_slot_partner (.pclk(pclk), .card_low_volt(low_volt),
    .iochrdy_o(iochrdy_o), .iochrdy_oe(iochrdy_oe), .zerows_n_o(zerows_n_o),
    .zerows_n_oe(zerows_n_oe), .sysclk(sysclk), .voltage_sense_input(sense),
    .iochrdy_i(iochrdy_i), .zerows_n_i(zerows_n_i));

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Waits for the line to be driven high, then counts how long the high drive lasts.
  task automatic kick(input logic zw);
    int n;
    n = 0;
    k = 0;
    while (n < 200 && (zw ? zerows_n_o : iochrdy_o) !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    while (k < 60 && (zw ? zerows_n_oe : iochrdy_oe) === 1'b1) begin
      k++;
      @(posedge pclk);
    end
    chk("kick_len", (k >= 1 && k <= 31), 1'b1);
  endtask

  // Starts a host memory command under the given qualifiers and checks acceptance.
  task automatic mem_try(input logic rn, input logic a, input logic ok);
    host.refresh_n <= rn;
    host.aen <= a;
    host.mem_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("mem_cycle", mem_cycle, ok);
    chk("dma_cycle", dma_cycle, a);
    if (ok) begin
      chk("ata_led", irq12_o, 1'b0);
      chk("rdy_hold", {iochrdy_oe, iochrdy_o}, 2'b10);
      kick(1'b0);
    end
    host.mem_req <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("mem_end", mem_cycle, 1'b0);
    host.refresh_n <= 1'b1;
    host.aen <= 1'b0;
    // Let an edge pass so a following call never reassigns the qualifiers in this step.
    @(posedge pclk);
  endtask

  // A hang cuts the run short with a counted mismatch.
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("power_rst", power, 4'hc);
    chk("host_interrupt_out_n_rst", host_interrupt_out_n_n, 1'b1);
    // Power selection table; rows with one select high also cover split pin wiring.
    foreach (rows[i]) begin
      apb(1'b1, csq_pkg::PWR_IDX, rows[i].pwr);
      apb(1'b1, csq_pkg::MIX_IDX, rows[i].mix);
      chk("power", power, rows[i].pw);
      apb(1'b0, csq_pkg::PWR_IDX, 8'h00);
      chk("pwr_rd", rd, {24'h0, rows[i].pwr});
    end
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped", {err, rd}, {1'b1, 32'h0});
    // Upper address latch follows while the strobe is high, then holds.
    host.bale <= 1'b1;
    host.la <= 7'h55;
    repeat (2) @(posedge pclk);
    chk("la_open", la_latched, 7'h55);
    host.bale <= 1'b0;
    host.la <= 7'h2a;
    repeat (2) @(posedge pclk);
    chk("la_held", la_latched, 7'h55);
    // Memory cycles under refresh and DMA, activity light in ATA mode.
    apb(1'b1, csq_pkg::CDC_IDX, 8'h10);
    mem_try(1'b1, 1'b0, 1'b1);
    mem_try(1'b0, 1'b0, 1'b0);
    mem_try(1'b1, 1'b1, 1'b0);
    // Zero-wait mode: line held low, then a short high kick after the command ends.
    apb(1'b1, csq_pkg::CDC_IDX, 8'h20);
    host.mem_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("zws_low", {zerows_n_oe, zerows_n_o}, 2'b10);
    host.mem_req <= 1'b0;
    kick(1'b1);
    // Sense change with its interrupt enabled.
    apb(1'b1, csq_pkg::CDC_IDX, 8'h04);
    low_volt <= 1'b1;
    k = 0;
    while (k < 10 && host_interrupt_out_n_n !== 1'b0) begin
      k++;
      @(posedge pclk);
    end
    chk("sense_irq", host_interrupt_out_n_n, 1'b0);
    k = 0;
    while (k < 300 && host_interrupt_out_n_n === 1'b0) begin
      k++;
      @(posedge pclk);
    end
    chk("irq_width", (k >= 90 && k <= 122), 1'b1);
    apb(1'b0, csq_pkg::IFS_IDX, 8'h00);
    chk("sense_bit", rd[7], 1'b1);
    apb(1'b0, csq_pkg::SC_IDX, 8'h00);
    chk("sc_gpi", rd, 32'h1);
    // Interrupt disabled, as software keeps it for voltage detection.
    apb(1'b1, csq_pkg::CDC_IDX, 8'h00);
    low_volt <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("no_irq", host_interrupt_out_n_n, 1'b1);
    apb(1'b0, csq_pkg::IFS_IDX, 8'h00);
    chk("sense_bit", rd[7], 1'b0);
    chk("ifs_lines", rd[1:0], 2'h3);
    // Software event and explicit clear, both paced by SYSCLK.
    apb(1'b1, csq_pkg::CDC_IDX, 8'h09);
    repeat (40) @(posedge pclk);
    apb(1'b0, csq_pkg::SC_IDX, 8'h00);
    chk("sc_event", rd, 32'h2);
    chk("irq12_flag", irq12_o, 1'b1);
    apb(1'b1, csq_pkg::SC_IDX, 8'h02);
    repeat (40) @(posedge pclk);
    apb(1'b0, csq_pkg::SC_IDX, 8'h00);
    chk("sc_clear", rd, 32'h0);
    chk("irq12_idle", irq12_o, 1'b0);
    // Reset in mid-run must switch every slot supply off.
    presetn <= 1'b0;
    @(posedge pclk);
    chk("power_rst2", power, 4'hc);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("host_interrupt_out_n_rst2", host_interrupt_out_n_n, 1'b1);
    chk("power_rel2", power, 4'hc);
    finish_test();
  end
endmodule
